//--- twp_pkg.sv
// Shared constants for the watchdog timer block: register map, fields, modes.
// Assumes one 32-bit AHB-Lite slave window with word-aligned registers.
package twp_pkg;
  localparam int          TWP_NUM_TMR   = 3;
  localparam int          TWP_CNT_W     = 24;
  localparam int          TWP_PRE_W     = 21;
  localparam logic [23:0] TWP_CNT_MAX   = 24'hFFFFFF;
  // Register offsets, per-timer group repeats at TWP_CH_STRIDE
  localparam logic [7:0]  TWP_CTRL_OFF  = 8'h00;
  localparam logic [7:0]  TWP_LOAD_OFF  = 8'h04;
  localparam logic [7:0]  TWP_CMP_OFF   = 8'h08;
  localparam logic [7:0]  TWP_CNT_OFF   = 8'h0C;
  localparam logic [7:0]  TWP_CH_STRIDE = 8'h10;
  localparam logic [7:0]  TWP_PLR_OFF   = 8'h30;
  localparam logic [7:0]  TWP_PCR_OFF   = 8'h34;
  // timer_control_status fields
  localparam int          TWP_RUN_BIT   = 0;
  localparam int          TWP_IRQEN_BIT = 2;
  localparam int          TWP_MODE_LSB  = 4;
  localparam int          TWP_SENSE_BIT = 8;
  localparam int          TWP_ARLD_BIT  = 9;
  localparam int          TWP_PSEL_BIT  = 15;
  localparam int          TWP_OFLG_BIT  = 20;
  localparam int          TWP_CFLG_BIT  = 21;
  // prescaler_load_register fields
  localparam int          TWP_SRC_LSB   = 21;
  localparam int          TWP_PRE_MSB   = 20;
  // Reset values
  localparam logic [23:0] TWP_RST_VAL   = 24'h000000;
  localparam logic [3:0]  TWP_MODE_RST  = 4'h0;
  // Watchdog modes
  localparam logic [3:0]  TWP_MODE_PULSE  = 4'h9;
  localparam logic [3:0]  TWP_MODE_TOGGLE = 4'hA;
  typedef enum logic [1:0] {
    TWP_SRC_HALF = 2'h0,
    TWP_SRC_PIN0 = 2'h1,
    TWP_SRC_PIN1 = 2'h2,
    TWP_SRC_PIN2 = 2'h3
  } twp_src_t;
endpackage

//--- twp_pin_sync.sv
// Three-flop synchroniser with agreement filter for one timer pin.
// Assumes the pin is asynchronous to hclk and slower than hclk/4.
`timescale 1ns/1ps
module twp_pin_sync (
  // Clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  // Pin and filtered results
  input  wire logic pin_in,
  output logic      level_q,
  output logic      rise_q
);
  logic s1_q;
  logic s2_q;
  logic s3_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_q    <= 1'b0;
      s2_q    <= 1'b0;
      s3_q    <= 1'b0;
      level_q <= 1'b0;
      rise_q  <= 1'b0;
    end else begin
      s1_q    <= pin_in;
      s2_q    <= s1_q;
      s3_q    <= s2_q;
      // Change accepted only when the second and third stage agree
      level_q <= (s2_q == s3_q) ? s2_q : level_q;
      rise_q  <= (s2_q == s3_q) && s2_q && !level_q;
    end
  end
endmodule

//--- twp_prescaler.sv
// Shared 21-bit prescaler down-counter feeding the timer channels.
// Assumes source ticks are single-cycle pulses already on hclk.
`timescale 1ns/1ps
module twp_prescaler import twp_pkg::*; (
  // Clock and reset
  input  wire logic                 hclk,
  input  wire logic                 hresetn,
  // Control
  input  wire logic                 enable,
  input  wire logic [1:0]           src,
  input  wire logic [TWP_PRE_W-1:0] preload,
  // Source ticks
  input  wire logic                 half_tick,
  input  wire logic [2:0]           pin_rise,
  // Results
  output logic [TWP_PRE_W-1:0]      cnt_q,
  output logic                      tick_q
);
  logic en_q;
  logic src_tick;

  always_comb begin
    unique case (twp_src_t'(src))
      TWP_SRC_HALF: src_tick = half_tick;
      TWP_SRC_PIN0: src_tick = pin_rise[0];
      TWP_SRC_PIN1: src_tick = pin_rise[1];
      TWP_SRC_PIN2: src_tick = pin_rise[2];
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      en_q   <= 1'b0;
      cnt_q  <= TWP_RST_VAL[TWP_PRE_W-1:0];
      tick_q <= 1'b0;
    end else begin
      en_q   <= enable;
      tick_q <= 1'b0;
      if (enable && !en_q) begin
        cnt_q <= preload;
      end else if (enable && src_tick) begin
        if (cnt_q == '0) begin
          cnt_q  <= preload;
          tick_q <= 1'b1;
        end else begin
          cnt_q <= cnt_q - TWP_PRE_W'(1);
        end
      end
    end
  end

  chk_prescale_div: assert property (@(posedge hclk) disable iff (!hresetn)
    (enable && en_q && src_tick && cnt_q == '0) |=> (tick_q && cnt_q == $past(preload)))
    else $error("prescaler did not reload at zero");
  chk_prescale_idle: assert property (@(posedge hclk) disable iff (!hresetn)
    (!enable && en_q) |=> ($stable(cnt_q) && !tick_q))
    else $error("prescaler moved while disabled");
endmodule

//--- twp_timer_top.sv
// Three watchdog timer channels with shared prescaler, AHB-Lite register slave.
// Assumes a single AHB-Lite master, word transfers, and a stop-state request level.
//
// Our own choices: the AHB-Lite slave port and the address map.
`timescale 1ns/1ps
// Overview of operation
// - Mode 9 is pulse watchdog, pin output
// - Pulse mode reloads after compare if auto-reload
// - Overflow pulses pin one timer clock, sense polarity
// - Load write while running reloads counter
// - Pin held 2.5 clocks after reset asserts
// - Mode 10 toggle watchdog, pin starts at sense
// - Toggle compare sets flag, interrupt if enabled
// - Toggle mode reloads after compare if auto-reload
// - Toggle mode overflow inverts pin level
// - Toggle mode load write reloads counter
// - Wait keeps counting, interrupts wake processor
// - Stop gates clocks, releases pins, ignores inputs
// - Every timer event issues a DMA trigger
// - Prescaler is 21-bit down-counter
// - Prescaler runs when enabled timer selects it
// - Prescaler source field at bits 22-21
// - Pin source independent of owner, synchronised
// - Bit 23 of prescaler load reads zero
// - Preload reloads at zero or enable
module twp_timer_top import twp_pkg::*; (
  // AHB-Lite slave
  input  wire logic                   hclk,
  input  wire logic                   hresetn,
  input  wire logic                   hsel,
  input  wire logic [31:0]            haddr,
  input  wire logic [1:0]             htrans,
  input  wire logic                   hwrite,
  input  wire logic [2:0]             hsize,
  input  wire logic [31:0]            hwdata,
  input  wire logic                   hready,
  output logic                        hreadyout,
  output logic [31:0]                 hrdata,
  output logic                        hresp,
  // Processor state
  input  wire logic                   stop_req,
  output logic                        wake_req,
  // Timer pins
  input  wire logic [TWP_NUM_TMR-1:0] timer_pin_in,
  output logic [TWP_NUM_TMR-1:0]      timer_pin_out,
  output logic [TWP_NUM_TMR-1:0]      timer_pin_oe_n,
  // Events
  output logic [TWP_NUM_TMR-1:0]      compare_irq,
  output logic [TWP_NUM_TMR-1:0]      dma_trigger
);
  localparam int N = TWP_NUM_TMR;

  function automatic logic reg_hit(input logic [7:0] a, input int ch, input logic [7:0] off);
    reg_hit = (a == 8'(int'(off) + ch * int'(TWP_CH_STRIDE)));
  endfunction

  // Bus state
  logic                   wr_pend_q;
  logic [7:0]             wa_q;
  logic [31:0]            hrdata_q;
  logic                   acc;
  logic [31:0]            rd_word;
  // Channel state
  logic [N-1:0]           run_q;
  logic [N-1:0]           run_d1_q;
  logic [N-1:0]           irqen_q;
  logic [N-1:0][3:0]      mode_q;
  logic [N-1:0]           sense_q;
  logic [N-1:0]           arld_q;
  logic [N-1:0]           psel_q;
  logic [N-1:0]           cflag_q;
  logic [N-1:0]           oflag_q;
  logic [N-1:0]           match_q;
  logic [N-1:0][23:0]     load_q;
  logic [N-1:0][23:0]     cmp_q;
  logic [N-1:0][23:0]     cnt_q;
  logic [N-1:0]           dma_q;
  logic [N-1:0]           pin_q;
  logic [N-1:0]           oe_n_q;
  // Shared state
  logic [23:0]            plr_q;
  logic                   half_q;
  logic                   rst_s1_q;
  logic                   rst_s2_q;
  logic                   pin_rstn_q;
  logic [N-1:0]           pin_rise;
  logic [TWP_PRE_W-1:0]   pre_cnt;
  logic                   pre_tick;
  logic                   pre_en;
  // Per-channel decode
  logic [N-1:0]           start;
  logic [N-1:0]           tick;
  logic [N-1:0]           cmp_ev;
  logic [N-1:0]           ovf_ev;
  logic [N-1:0]           wd_mode;
  logic [N-1:0]           wr_ctrl;
  logic [N-1:0]           wr_load;
  logic [N-1:0]           wr_cmp;

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_q;
  assign acc       = hsel && hready && htrans[1];

  // Zero-wait slave: writes land in the data phase, reads are fetched in the address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wa_q      <= 8'h00;
      hrdata_q  <= 32'h00000000;
    end else begin
      wr_pend_q <= acc && hwrite;
      if (acc) begin
        wa_q <= haddr[7:0];
      end
      hrdata_q <= (acc && !hwrite) ? rd_word : 32'h00000000;
    end
  end

  always_comb begin
    rd_word = 32'h00000000;
    for (int i = 0; i < N; i++) begin
      if (reg_hit(haddr[7:0], i, TWP_CTRL_OFF)) begin
        rd_word[TWP_RUN_BIT]                 = run_q[i];
        rd_word[TWP_IRQEN_BIT]               = irqen_q[i];
        rd_word[TWP_MODE_LSB+3:TWP_MODE_LSB] = mode_q[i];
        rd_word[TWP_SENSE_BIT]               = sense_q[i];
        rd_word[TWP_ARLD_BIT]                = arld_q[i];
        rd_word[TWP_PSEL_BIT]                = psel_q[i];
        rd_word[TWP_OFLG_BIT]                = oflag_q[i];
        rd_word[TWP_CFLG_BIT]                = cflag_q[i];
      end
      if (reg_hit(haddr[7:0], i, TWP_LOAD_OFF)) begin
        rd_word[23:0] = load_q[i];
      end
      if (reg_hit(haddr[7:0], i, TWP_CMP_OFF)) begin
        rd_word[23:0] = cmp_q[i];
      end
      if (reg_hit(haddr[7:0], i, TWP_CNT_OFF)) begin
        rd_word[23:0] = cnt_q[i];
      end
    end
    if (haddr[7:0] == TWP_PLR_OFF) begin
      rd_word[22:0] = plr_q[22:0];
    end
    if (haddr[7:0] == TWP_PCR_OFF) begin
      rd_word[TWP_PRE_W-1:0] = pre_cnt;
    end
  end

  always_comb begin
    for (int i = 0; i < N; i++) begin
      wr_ctrl[i] = wr_pend_q && reg_hit(wa_q, i, TWP_CTRL_OFF);
      wr_load[i] = wr_pend_q && reg_hit(wa_q, i, TWP_LOAD_OFF);
      wr_cmp[i]  = wr_pend_q && reg_hit(wa_q, i, TWP_CMP_OFF);
      wd_mode[i] = (mode_q[i] == TWP_MODE_PULSE) || (mode_q[i] == TWP_MODE_TOGGLE);
      start[i]   = run_q[i] && !run_d1_q[i];
      // Stop gates every timer clock; wait has no effect here
      tick[i]    = run_q[i] && !stop_req && (psel_q[i] ? pre_tick : half_q);
      cmp_ev[i]  = tick[i] && (cnt_q[i] == cmp_q[i]);
      ovf_ev[i]  = tick[i] && (cnt_q[i] == TWP_CNT_MAX) && !(match_q[i] && arld_q[i]);
    end
  end

  // Internal CLK/2 timer clock
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      half_q <= 1'b0;
    end else begin
      half_q <= !half_q;
    end
  end

  // Control registers; hardware-set flags win over a clearing write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      run_q   <= '0;
      irqen_q <= '0;
      mode_q  <= {N{TWP_MODE_RST}};
      sense_q <= '0;
      arld_q  <= '0;
      psel_q  <= '0;
      cflag_q <= '0;
      oflag_q <= '0;
      load_q  <= '0;
      cmp_q   <= '0;
      plr_q   <= TWP_RST_VAL;
    end else begin
      for (int i = 0; i < N; i++) begin
        if (wr_ctrl[i]) begin
          run_q[i]   <= hwdata[TWP_RUN_BIT];
          irqen_q[i] <= hwdata[TWP_IRQEN_BIT];
          mode_q[i]  <= hwdata[TWP_MODE_LSB+3:TWP_MODE_LSB];
          sense_q[i] <= hwdata[TWP_SENSE_BIT];
          arld_q[i]  <= hwdata[TWP_ARLD_BIT];
          psel_q[i]  <= hwdata[TWP_PSEL_BIT];
        end
        cflag_q[i] <= cmp_ev[i] || (cflag_q[i] && !(wr_ctrl[i] && hwdata[TWP_CFLG_BIT]));
        oflag_q[i] <= ovf_ev[i] || (oflag_q[i] && !(wr_ctrl[i] && hwdata[TWP_OFLG_BIT]));
        if (wr_load[i]) begin
          load_q[i] <= hwdata[23:0];
        end
        if (wr_cmp[i]) begin
          cmp_q[i] <= hwdata[23:0];
        end
      end
      if (wr_pend_q && wa_q == TWP_PLR_OFF) begin
        plr_q <= {1'b0, hwdata[22:0]};
      end
    end
  end

  // Counters, compare tracking and DMA triggers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      run_d1_q <= '0;
      cnt_q    <= '0;
      match_q  <= '0;
      dma_q    <= '0;
    end else begin
      run_d1_q <= run_q;
      for (int i = 0; i < N; i++) begin
        dma_q[i] <= cmp_ev[i] || ovf_ev[i];
        if (start[i]) begin
          cnt_q[i]   <= load_q[i];
          match_q[i] <= 1'b0;
        end else if (wr_load[i] && run_q[i]) begin
          cnt_q[i]   <= hwdata[23:0];
          match_q[i] <= 1'b0;
        end else if (tick[i]) begin
          match_q[i] <= (cnt_q[i] == cmp_q[i]);
          if (match_q[i] && arld_q[i]) begin
            cnt_q[i] <= load_q[i];
          end else begin
            cnt_q[i] <= cnt_q[i] + 24'h000001;
          end
        end
      end
    end
  end

  // Pin reset lags hresetn by 2.5 clocks so a pin-driven reset has full length
  always_ff @(posedge hclk) begin
    rst_s1_q <= hresetn;
    rst_s2_q <= rst_s1_q;
  end

  always_ff @(negedge hclk) begin
    pin_rstn_q <= rst_s2_q;
  end

  always_ff @(posedge hclk or negedge pin_rstn_q) begin
    if (!pin_rstn_q) begin
      pin_q  <= '0;
      oe_n_q <= '1;
    end else if (hresetn) begin
      for (int i = 0; i < N; i++) begin
        oe_n_q[i] <= !(wd_mode[i] && run_q[i] && !stop_req);
        if (mode_q[i] == TWP_MODE_PULSE) begin
          if (start[i]) begin
            pin_q[i] <= !sense_q[i];
          end else if (tick[i]) begin
            pin_q[i] <= ovf_ev[i] ? sense_q[i] : !sense_q[i];
          end
        end else if (mode_q[i] == TWP_MODE_TOGGLE) begin
          if (start[i]) begin
            pin_q[i] <= sense_q[i];
          end else if (ovf_ev[i]) begin
            pin_q[i] <= !pin_q[i];
          end
        end
      end
    end
  end

  assign timer_pin_out  = pin_q;
  assign timer_pin_oe_n = oe_n_q;
  assign dma_trigger    = dma_q;
  assign compare_irq    = cflag_q & irqen_q;
  assign wake_req       = |compare_irq;

  // Prescaler runs only for a running timer that selects it; pin changes ignored in stop
  assign pre_en = |(run_q & psel_q) && !stop_req;

  // Only filtered rising edges are used; the settled level has no reader here
  for (genvar g = 0; g < N; g++) begin : g_sync
    twp_pin_sync u_sync (
      .hclk    (hclk),
      .hresetn (hresetn),
      .pin_in  (timer_pin_in[g]),
      .level_q (),
      .rise_q  (pin_rise[g])
    );
  end

  twp_prescaler u_pre (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .enable    (pre_en),
    .src       (plr_q[TWP_SRC_LSB+1:TWP_SRC_LSB]),
    .preload   (plr_q[TWP_PRE_MSB:0]),
    .half_tick (half_q),
    .pin_rise  (pin_rise & {N{!stop_req}}),
    .cnt_q     (pre_cnt),
    .tick_q    (pre_tick)
  );

  for (genvar g = 0; g < N; g++) begin : g_chk
    chk_pulse_width: assert property (@(posedge hclk) disable iff (!hresetn)
      (mode_q[g] == TWP_MODE_PULSE && ovf_ev[g] && !start[g]) |=>
        (timer_pin_out[g] == sense_q[g]))
      else $error("pulse watchdog missed its pulse");
    chk_toggle_invert: assert property (@(posedge hclk) disable iff (!hresetn)
      (mode_q[g] == TWP_MODE_TOGGLE && ovf_ev[g] && !start[g]) |=>
        (timer_pin_out[g] != $past(timer_pin_out[g])))
      else $error("toggle watchdog did not invert");
    chk_toggle_start: assert property (@(posedge hclk) disable iff (!hresetn)
      (mode_q[g] == TWP_MODE_TOGGLE && start[g]) |=> (timer_pin_out[g] == sense_q[g]))
      else $error("toggle watchdog started at wrong level");
    chk_reload_next: assert property (@(posedge hclk) disable iff (!hresetn)
      (tick[g] && match_q[g] && arld_q[g] && !start[g] && !wr_load[g]) |=>
        (cnt_q[g] == $past(load_q[g])))
      else $error("auto reload missed");
    chk_load_write: assert property (@(posedge hclk) disable iff (!hresetn)
      (wr_load[g] && run_q[g] && !start[g]) |=> (cnt_q[g] == $past(hwdata[23:0])))
      else $error("load write did not reload counter");
    chk_cmp_flag: assert property (@(posedge hclk) disable iff (!hresetn)
      cmp_ev[g] |=> (cflag_q[g] && (compare_irq[g] == irqen_q[g])))
      else $error("compare flag not set");
    chk_dma_event: assert property (@(posedge hclk) disable iff (!hresetn)
      (cmp_ev[g] || ovf_ev[g]) |=> dma_trigger[g])
      else $error("event without DMA trigger");
    chk_stop_gate: assert property (@(posedge hclk) disable iff (!hresetn)
      stop_req |=> ($stable(cnt_q[g]) || $past(wr_load[g]) || $past(start[g])))
      else $error("counter moved in stop");
  end

  chk_plr_resvd: assert property (@(posedge hclk) disable iff (!hresetn)
    (acc && !hwrite && haddr[7:0] == TWP_PLR_OFF) |=> (hrdata[31:23] == 9'h000))
    else $error("reserved prescaler bit read nonzero");
endmodule

//--- twp_ext_circuit.sv
// Model of the circuitry outside the timer pins: it reads the pins the block drives
// and drives a slow square wave onto every pin that the block has released.
`timescale 1ns/1ps
module twp_ext_circuit (
  // Clock
  input  wire logic       hclk,
  // Block side of the pins
  input  wire logic [2:0] pin_out,
  input  wire logic [2:0] pin_oe_n,
  // Resolved pin levels
  output logic [2:0]      pin_wire
);
  logic [3:0] div_q;
  logic       wave_q;
  initial begin
    div_q  = 4'h0;
    wave_q = 1'b0;
  end
  // Twelve hclk per period keeps the external clock well below CLK/4
  always @(posedge hclk) begin
    div_q <= (div_q == 4'h5) ? 4'h0 : div_q + 4'h1;
    if (div_q == 4'h5) begin
      wave_q <= ~wave_q;
    end
  end
  // The block wins wherever its enable is low
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      pin_wire[i] = pin_oe_n[i] ? wave_q : pin_out[i];
    end
  end
endmodule

//--- testbench.sv
// Self-checking bench for the watchdog timer block over AHB-Lite.
// Assumes zero-wait-state slave and the register map of the package.
`timescale 1ns/1ps
module testbench import twp_pkg::*;;
  logic        hclk, hresetn, hsel, hwrite, stop_req;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize, pin_wire, pin_out, oe_n, irq, dma;
  logic        hreadyout, hresp, wake_req;
  int          bad_count, tests_run, dma_n;
  logic [31:0] a, b;

  initial begin
    hclk = 0; hresetn = 0; hsel = 0; hwrite = 0; stop_req = 0;
    haddr = 0; hwdata = 0; htrans = 0; hsize = 3'h2;
  end
  always #12.5 hclk = ~hclk;

  twp_timer_top dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .stop_req(stop_req),
    .wake_req(wake_req), .timer_pin_in(pin_wire), .timer_pin_out(pin_out),
    .timer_pin_oe_n(oe_n), .compare_irq(irq), .dma_trigger(dma));
  twp_ext_circuit ext_u (.hclk(hclk), .pin_out(pin_out), .pin_oe_n(oe_n), .pin_wire(pin_wire));

  // Each trigger is taken in the cycle it appears, before the next can come
  always @(posedge hclk) if (dma[0] === 1'b1) dma_n++;

  task automatic conclude();
    if (bad_count == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #(25 * 20000);
    bad_count++;
    conclude();
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rng(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
    tests_run++;
    if (!(got >= lo && got <= hi) || $isunknown(got)) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h..%h", $time, got, lo, hi);
    end
  endtask
  // One single word transfer; read data taken at the data-phase edge
  task automatic bus(input logic [7:0] ad, input logic w, input logic [31:0] d,
                     output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1'b1; haddr <= {24'h0, ad}; hwrite <= w; htrans <= 2'b10;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0; htrans <= 2'b00; hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    logic [31:0] r;
    bus(ad, 1'b1, d, r);
  endtask
  task automatic rd(input logic [7:0] ad, output logic [31:0] r);
    bus(ad, 1'b0, 32'h0, r);
  endtask
  function automatic logic [7:0] ra(input logic [7:0] i, input logic [7:0] off);
    ra = off + TWP_CH_STRIDE * i;
  endfunction
  function automatic logic [31:0] ctl(input logic [3:0] m, input logic s, input logic ar,
                                      input logic ie, input logic ps);
    ctl = 32'h1 | ({31'h0, ie} << TWP_IRQEN_BIT) | ({28'h0, m} << TWP_MODE_LSB)
        | ({31'h0, s} << TWP_SENSE_BIT) | ({31'h0, ar} << TWP_ARLD_BIT)
        | ({31'h0, ps} << TWP_PSEL_BIT);
  endfunction
  task automatic wait_pin(input int i, input logic v);
    int n;
    n = 0;
    while (pin_out[i] !== v && n < 200) begin
      @(posedge hclk); #1; n++;
    end
    chk({31'h0, pin_out[i]}, {31'h0, v});
  endtask
  task automatic start(input int i, input logic [31:0] ld, input logic [31:0] cp,
                       input logic [31:0] c);
    wr(ra(i[7:0], TWP_LOAD_OFF), ld);
    wr(ra(i[7:0], TWP_CMP_OFF), cp);
    wr(ra(i[7:0], TWP_CTRL_OFF), c);
    @(posedge hclk); #1;
  endtask

  initial begin
    int n;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    rd(TWP_PLR_OFF, a); chk(a, 32'h0);
    rd(8'h3C, a); chk(a, 32'h0);
    chk({31'h0, hresp}, 32'h0);
    wr(TWP_PLR_OFF, 32'hFFFFFFFF);
    rd(TWP_PLR_OFF, a); chk(a, 32'h007FFFFF);
    // Toggle watchdog, sense low, compare interrupt enabled; mode codes avoid 8 and 11..15
    start(0, 32'hFFFFF0, 32'hFFFFF4, ctl(TWP_MODE_TOGGLE, 0, 0, 1, 0));
    chk({31'h0, pin_out[0]}, 32'h0); chk({31'h0, oe_n[0]}, 32'h0);
    wait_pin(0, 1'b1);
    chk({31'h0, irq[0]}, 32'h1); chk({31'h0, wake_req}, 32'h1);
    rd(ra(0, TWP_CTRL_OFF), a); chk({31'h0, a[TWP_CFLG_BIT]}, 32'h1);
    rng(dma_n, 2, 4);
    wr(ra(0, TWP_LOAD_OFF), 32'h000100);
    rd(ra(0, TWP_CNT_OFF), a); rng(a, 32'h100, 32'h104);
    // Stop state releases the pin and freezes counting
    stop_req <= 1'b1;
    repeat (3) @(posedge hclk); #1;
    chk({31'h0, oe_n[0]}, 32'h1);
    rd(ra(0, TWP_CNT_OFF), a); repeat (10) @(posedge hclk);
    rd(ra(0, TWP_CNT_OFF), b); chk(b, a);
    stop_req <= 1'b0;
    // Pulse watchdog, sense high: pin idles low, one timer-clock pulse at overflow
    start(1, 32'hFFFFF8, 32'hFFFFF9, ctl(TWP_MODE_PULSE, 1, 0, 0, 0));
    chk({31'h0, oe_n[1]}, 32'h0); chk({31'h0, pin_out[1]}, 32'h0);
    wait_pin(1, 1'b1);
    n = 0;
    while (pin_out[1] === 1'b1 && n < 10) begin
      @(posedge hclk); #1; n++;
    end
    chk(n, 2);
    wr(ra(1, TWP_LOAD_OFF), 32'h000200);
    rd(ra(1, TWP_CNT_OFF), a); rng(a, 32'h200, 32'h204);
    // Auto-reload keeps the counter between load and compare plus one
    start(2, 32'hFFFFF8, 32'hFFFFFA, ctl(TWP_MODE_TOGGLE, 0, 1, 0, 0));
    repeat (60) @(posedge hclk);
    rd(ra(2, TWP_CNT_OFF), a); rng(a, 32'hFFFFF8, 32'hFFFFFB);
    chk({31'h0, pin_out[2]}, 32'h0);
    start(1, 32'hFFFFF8, 32'hFFFFFA, ctl(TWP_MODE_PULSE, 1, 1, 0, 0));
    repeat (60) @(posedge hclk);
    rd(ra(1, TWP_CNT_OFF), a); rng(a, 32'hFFFFF8, 32'hFFFFFB);
    // Prescaler from every source; pins released so the outside drives them
    wr(ra(0, TWP_CTRL_OFF), 32'h0);
    wr(ra(1, TWP_CTRL_OFF), 32'h0);
    for (int s = 0; s < 4; s++) begin
      wr(ra(2, TWP_CTRL_OFF), 32'h0);
      wr(TWP_PLR_OFF, {9'h0, s[1:0], 21'h7});
      wr(ra(2, TWP_CTRL_OFF), ctl(4'h0, 0, 0, 0, 1));
      repeat (40) @(posedge hclk);
      rd(TWP_PCR_OFF, a); rng(a, 0, 7);
      repeat (40) @(posedge hclk);
      rd(TWP_PCR_OFF, b); tests_run++;
      if (a === b) begin
        bad_count++;
        $display("mismatch at %0t: got %h expected not %h", $time, b, a);
      end
    end
    wr(ra(2, TWP_CTRL_OFF), 32'h0);
    rd(TWP_PCR_OFF, a); repeat (30) @(posedge hclk);
    rd(TWP_PCR_OFF, b); chk(b, a);
    // Pin level and direction survive two and a half clocks into reset
    start(0, 32'h0, 32'hFFFFFF, ctl(TWP_MODE_TOGGLE, 1, 0, 0, 0));
    chk({31'h0, pin_out[0]}, 32'h1);
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk); #1;
    chk({31'h0, pin_out[0]}, 32'h1); chk({31'h0, oe_n[0]}, 32'h0);
    @(negedge hclk); #1;
    chk({31'h0, oe_n[0]}, 32'h1);
    @(posedge hclk);
    hresetn <= 1'b1;
    conclude();
  end
endmodule
